// >>> rtl/crs_core.v
/*
  Register set and operand-format datapath of a 32-bit RISC core with
  fixed 16-bit instructions, with an AHB-Lite word view of every register.
  Assumes instruction words are supplied for fetch_addr on the same clock,
  data memory returns right-justified data with mem_ack, one AHB master.
*/
// Local design decisions: register access over AHB-Lite and the register addresses.
// Operation
// - Sixteen general, three control and four system registers, all 32-bit.
// - Register zero is the index register and fixed operand of some ops.
// - Register fifteen is the stack pointer for exception save and restore.
// - Global base gives the base for base-relative peripheral moves.
// - Vector base locates the exception and interrupt vector area.
// - Multiply results go to the low accumulator; accumulate results go to the accumulator pair.
// - Return-link register holds the subroutine return address.
// - After reset the stack pointer is loaded from the vector table.
// - After reset the program counter is loaded from the vector table.
// - Reset sets mask field to ones and clears reserved status bits.
// - Byte and word loads are sign-extended to 32 bits.
// - Misaligned word or longword access raises an address error.
// - Stack is reached only by aligned longword transfers.
// - Move, add and compare-equal sign-extend byte immediates.
// - Test, and, or, xor zero-extend byte immediates.
// - Wider immediates come from a program-counter-relative table.
// - Every instruction is one fixed 16-bit word.
// - Basic instructions complete one per clock.
// - Arithmetic is register-only; bit logic may work on memory.
// - Unconditional branches run the following slot instruction first.
// - Conditional branches come delayed and ordinary.
`include "crs_map.vh"
`default_nettype none
module crs_core (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire [31:0] hrdata,
  output wire        hresp,
  input  wire        insn_valid,
  input  wire [15:0] insn,
  output wire        insn_ready,
  output wire [31:0] fetch_addr,
  output wire        mem_req,
  output wire [31:0] mem_addr,
  output wire        mem_we,
  output wire [1:0]  mem_size,
  output wire [31:0] mem_wdata,
  input  wire [31:0] mem_rdata,
  input  wire        mem_ack,
  output wire        addr_err
);
  localparam [8:0] S_VPC = 9'h001;
  localparam [8:0] S_VSP = 9'h002;
  localparam [8:0] S_RUN = 9'h004;
  localparam [8:0] S_MEM = 9'h008;
  localparam [8:0] S_PSR = 9'h010;
  localparam [8:0] S_PPC = 9'h020;
  localparam [8:0] S_VEC = 9'h040;
  localparam [8:0] S_OPC = 9'h080;
  localparam [8:0] S_OSR = 9'h100;

  reg [31:0] gpr [0:15];
  reg [8:0]  state_q;
  reg [31:0] sr_q;
  reg [31:0] gbr_q;
  reg [31:0] vbr_q;
  reg [31:0] accumulator_high_q;
  reg [31:0] accumulator_low_q;
  reg [31:0] pr_q;
  reg [31:0] pc_q;
  reg        br_pend_q;
  reg [31:0] br_tgt_q;
  reg        mem_req_q;
  reg        mem_we_q;
  reg [1:0]  mem_size_q;
  reg [31:0] mem_addr_q;
  reg [31:0] mem_wdata_q;
  reg [3:0]  ld_dst_q;
  reg        rmw_q;
  reg [1:0]  rmw_op_q;
  reg [7:0]  rmw_imm_q;
  reg [7:0]  vec_q;
  reg [31:0] epc_q;
  reg        err_q;
  reg        addr_err_q;
  reg        halt_q;
  reg        bus_wr_q;
  reg [4:0]  bus_idx_q;
  reg [31:0] hrdata_q;

  wire [3:0]  op   = insn[15:12];
  wire [3:0]  rn   = insn[11:8];
  wire [3:0]  rm   = insn[7:4];
  wire [7:0]  imm  = insn[7:0];
  wire [31:0] rnv  = gpr[rn];
  wire [31:0] rmv  = gpr[rm];
  wire [31:0] r0   = gpr[0];
  wire [31:0] sp   = gpr[15];
  wire [31:0] simm = {{24{imm[7]}}, imm};
  wire [31:0] zimm = {24'h0, imm};
  wire [31:0] sp_al = {sp[31:2], 2'h0};
  wire        t_bit = sr_q[`CRS_SR_T];

  assign insn_ready = (state_q == S_RUN) && !halt_q && ce;
  wire exec = insn_ready && insn_valid;
  wire [31:0] pc_seq  = pc_q + `CRS_INSN_STEP;
  wire [31:0] pc_next = br_pend_q ? br_tgt_q : pc_seq;
  wire [31:0] br_tgt  = pc_q + `CRS_PC_AHEAD + {simm[30:0], 1'h0};
  wire signed [63:0] prod = $signed(rnv) * $signed(rmv);
  wire [63:0] mac_sum = {accumulator_high_q, accumulator_low_q} + prod;

  wire        acc = hsel && htrans[1] && hready && (hsize == `CRS_HSIZE_WORD);
  wire [4:0]  acc_idx = haddr[6:2];
  wire        acc_hit = (haddr[31:7] == 25'h0) && (acc_idx <= `CRS_IX_CTRL);

  function [31:0] ld_ext(input [1:0] sz, input [31:0] d);
    begin
      case (sz)
        `CRS_SZ_B: ld_ext = {{24{d[7]}}, d[7:0]};
        `CRS_SZ_W: ld_ext = {{16{d[15]}}, d[15:0]};
        default:   ld_ext = d;
      endcase
    end
  endfunction

  function [31:0] lop(input [1:0] s, input [31:0] a, input [31:0] b);
    begin
      case (s)
        `CRS_LG_OR:  lop = a | b;
        `CRS_LG_XOR: lop = a ^ b;
        default:     lop = a & b;
      endcase
    end
  endfunction

  function [31:0] rd_mux(input [4:0] ix);
    begin
      case (ix)
        `CRS_IX_SR:   rd_mux = sr_q;
        `CRS_IX_GBR:  rd_mux = gbr_q;
        `CRS_IX_VBR:  rd_mux = vbr_q;
        `CRS_IX_ACCUMULATOR_HIGH: rd_mux = accumulator_high_q;
        `CRS_IX_ACCUMULATOR_LOW: rd_mux = accumulator_low_q;
        `CRS_IX_PR:   rd_mux = pr_q;
        `CRS_IX_PC:   rd_mux = pc_q;
        `CRS_IX_STAT: rd_mux = {22'h0, state_q, err_q};
        `CRS_IX_CTRL: rd_mux = {31'h0, halt_q};
        default:      rd_mux = ix[4] ? 32'h0 : gpr[ix[3:0]];
      endcase
    end
  endfunction

  wire [31:0] ctl_rd = (imm[1:0] == `CRS_CS_SR) ? sr_q :
                       (imm[1:0] == `CRS_CS_GBR) ? gbr_q : vbr_q;
  wire [31:0] sys_rd = (imm[1:0] == `CRS_SS_ACCUMULATOR_HIGH) ? accumulator_high_q :
                       (imm[1:0] == `CRS_SS_ACCUMULATOR_LOW) ? accumulator_low_q : pr_q;

  reg [31:0] ma;
  reg [1:0]  msz;
  reg        mwe;
  reg [31:0] mwd;
  reg        mop;
  always @* begin
    ma  = r0 + rmv;
    msz = insn[1] ? `CRS_SZ_L : {1'h0, insn[0]};
    mwe = 1'h0;
    mwd = rnv;
    mop = 1'h1;
    case (op)
      `CRS_OP_LOAD: mwe = 1'h0;
      `CRS_OP_STORE: mwe = 1'h1;
      `CRS_OP_LDPC: begin
        msz = insn[7] ? `CRS_SZ_L : `CRS_SZ_W;
        ma  = insn[7] ? ({pc_q[31:2], 2'h0} + `CRS_PC_AHEAD + {23'h0, imm[6:0], 2'h0})
                      : (pc_q + `CRS_PC_AHEAD + {24'h0, imm[6:0], 1'h0});
      end
      `CRS_OP_GBRM: begin
        ma  = gbr_q + {22'h0, imm, 2'h0};
        msz = `CRS_SZ_L;
        mwe = insn[8];
        mwd = r0;
      end
      `CRS_OP_BITM: begin
        ma  = gbr_q + r0;
        msz = `CRS_SZ_B;
      end
      default: mop = 1'h0;
    endcase
  end

  wire misal = ((msz == `CRS_SZ_W) && ma[0]) || ((msz == `CRS_SZ_L) && (ma[1:0] != 2'h0));

  reg        gw_en;
  reg [3:0]  gw_idx;
  reg [31:0] gw_dat;
  always @* begin
    gw_en  = 1'h0;
    gw_idx = rn;
    gw_dat = 32'h0;
    if (bus_wr_q && !bus_idx_q[4]) begin
      gw_en  = 1'h1;
      gw_idx = bus_idx_q[3:0];
      gw_dat = hwdata;
    end else begin
      case (state_q)
        S_RUN: if (exec && !mop) begin
          case (op)
            `CRS_OP_MOVI: begin gw_en = 1'h1; gw_dat = simm; end
            `CRS_OP_ADDI: begin gw_en = 1'h1; gw_dat = rnv + simm; end
            `CRS_OP_ADD:  begin gw_en = 1'h1; gw_dat = rnv + rmv; end
            `CRS_OP_LOGI: if (rn[1:0] != `CRS_LG_TST) begin
              gw_en  = 1'h1;
              gw_idx = 4'h0;
              gw_dat = lop(rn[1:0], r0, zimm);
            end
            `CRS_OP_CTL: if (rn == `CRS_CTL_STC || rn == `CRS_CTL_STS) begin
              gw_en  = 1'h1;
              gw_idx = rm;
              gw_dat = (rn == `CRS_CTL_STC) ? ctl_rd : sys_rd;
            end
            default: gw_en = 1'h0;
          endcase
        end
        S_MEM: if (mem_req_q && mem_ack && !mem_we_q && !rmw_q) begin
          gw_en  = 1'h1;
          gw_idx = ld_dst_q;
          gw_dat = ld_ext(mem_size_q, mem_rdata);
        end
        S_PSR, S_PPC: if (!mem_req_q) begin
          gw_en  = 1'h1;
          gw_idx = 4'hf;
          gw_dat = sp_al - `CRS_STK_STEP;
        end
        S_OPC, S_OSR: if (mem_req_q && mem_ack) begin
          gw_en  = 1'h1;
          gw_idx = 4'hf;
          gw_dat = sp_al + `CRS_STK_STEP;
        end
        S_VSP: if (mem_req_q && mem_ack) begin
          gw_en  = 1'h1;
          gw_idx = 4'hf;
          gw_dat = mem_rdata;
        end
        default: gw_en = 1'h0;
      endcase
    end
  end

  always @(posedge hclk) begin
    if (ce && gw_en) begin
      gpr[gw_idx] <= gw_dat;
    end
  end

  task issue(input [31:0] a, input w, input [1:0] s, input [31:0] d);
    begin
      mem_req_q   <= 1'h1;
      mem_addr_q  <= a;
      mem_we_q    <= w;
      mem_size_q  <= s;
      mem_wdata_q <= d;
    end
  endtask

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_VPC;
      sr_q <= `CRS_SR_RESET;
      vbr_q <= `CRS_VBR_RESET;
      gbr_q <= 32'h0;
      accumulator_high_q <= 32'h0;
      accumulator_low_q <= 32'h0;
      pr_q <= 32'h0;
      pc_q <= 32'h0;
      br_pend_q <= 1'h0;
      br_tgt_q <= 32'h0;
      mem_req_q <= 1'h0;
      mem_we_q <= 1'h0;
      mem_size_q <= `CRS_SZ_L;
      mem_addr_q <= 32'h0;
      mem_wdata_q <= 32'h0;
      ld_dst_q <= 4'h0;
      rmw_q <= 1'h0;
      rmw_op_q <= `CRS_LG_AND;
      rmw_imm_q <= 8'h0;
      vec_q <= 8'h0;
      epc_q <= 32'h0;
      err_q <= 1'h0;
      addr_err_q <= 1'h0;
      halt_q <= 1'h0;
      bus_wr_q <= 1'h0;
      bus_idx_q <= `CRS_IX_NONE;
      hrdata_q <= 32'h0;
    end else if (ce) begin
      addr_err_q <= 1'h0;
      bus_wr_q <= acc && hwrite;
      if (acc) begin
        bus_idx_q <= acc_hit ? acc_idx : `CRS_IX_NONE;
        hrdata_q  <= (acc_hit && !hwrite) ? rd_mux(acc_idx) : 32'h0;
      end
      // Clear first so a same-cycle error still sets the flag
      if (bus_wr_q && bus_idx_q == `CRS_IX_STAT && hwdata[`CRS_STAT_ERR]) begin
        err_q <= 1'h0;
      end
      case (state_q)
        S_VPC: if (!mem_req_q) begin
          issue(vbr_q + `CRS_VEC_PC_OFF, 1'h0, `CRS_SZ_L, 32'h0);
        end else if (mem_ack) begin
          mem_req_q <= 1'h0;
          pc_q <= mem_rdata;
          state_q <= S_VSP;
        end
        S_VSP: if (!mem_req_q) begin
          issue(vbr_q + `CRS_VEC_SP_OFF, 1'h0, `CRS_SZ_L, 32'h0);
        end else if (mem_ack) begin
          mem_req_q <= 1'h0;
          state_q <= S_RUN;
        end
        S_RUN: if (exec) begin
          pc_q <= pc_next;
          br_pend_q <= 1'h0;
          if (mop && misal) begin
            addr_err_q <= 1'h1;
            err_q <= 1'h1;
            vec_q <= `CRS_VEC_ADRERR;
            epc_q <= pc_next;
            state_q <= S_PSR;
          end else if (mop) begin
            issue(ma, mwe, msz, mwd);
            ld_dst_q <= (op == `CRS_OP_GBRM) ? 4'h0 : rn;
            rmw_q <= (op == `CRS_OP_BITM);
            rmw_op_q <= rn[1:0];
            rmw_imm_q <= imm;
            state_q <= S_MEM;
          end else begin
            case (op)
              `CRS_OP_CMPI: sr_q[`CRS_SR_T] <= (rnv == simm);
              `CRS_OP_LOGI: if (rn[1:0] == `CRS_LG_TST) begin
                sr_q[`CRS_SR_T] <= ((r0 & zimm) == 32'h0);
              end
              `CRS_OP_MUL: accumulator_low_q <= prod[31:0];
              `CRS_OP_MAC: begin
                accumulator_high_q <= mac_sum[63:32];
                accumulator_low_q <= mac_sum[31:0];
              end
              `CRS_OP_BRA: begin
                br_pend_q <= 1'h1;
                br_tgt_q <= br_tgt;
              end
              `CRS_OP_BSR: begin
                br_pend_q <= 1'h1;
                br_tgt_q <= br_tgt;
                pr_q <= pc_q + `CRS_PC_AHEAD;
              end
              `CRS_OP_BCC: if (rn[0] ^ t_bit) begin
                if (rn[1]) begin
                  br_pend_q <= 1'h1;
                  br_tgt_q <= br_tgt;
                end else begin
                  pc_q <= br_tgt;
                end
              end
              `CRS_OP_CTL: begin
                case (rn)
                  `CRS_CTL_RTS: begin
                    br_pend_q <= 1'h1;
                    br_tgt_q <= pr_q;
                  end
                  `CRS_CTL_RTE: state_q <= S_OPC;
                  `CRS_CTL_TRAP: begin
                    vec_q <= imm;
                    epc_q <= pc_next;
                    state_q <= S_PSR;
                  end
                  `CRS_CTL_LDC: begin
                    if (imm[1:0] == `CRS_CS_SR) sr_q <= rmv & `CRS_SR_WMASK;
                    else if (imm[1:0] == `CRS_CS_GBR) gbr_q <= rmv;
                    else vbr_q <= rmv;
                  end
                  `CRS_CTL_LDS: begin
                    if (imm[1:0] == `CRS_SS_ACCUMULATOR_HIGH) accumulator_high_q <= rmv;
                    else if (imm[1:0] == `CRS_SS_ACCUMULATOR_LOW) accumulator_low_q <= rmv;
                    else pr_q <= rmv;
                  end
                  default: br_pend_q <= 1'h0;
                endcase
              end
              default: br_pend_q <= 1'h0;
            endcase
          end
        end
        S_MEM: if (mem_ack) begin
          mem_req_q <= 1'h0;
          if (rmw_q && !mem_we_q) begin
            issue(mem_addr_q, 1'h1, mem_size_q, lop(rmw_op_q, mem_rdata, {24'h0, rmw_imm_q}));
          end else begin
            state_q <= S_RUN;
          end
        end
        S_PSR: if (!mem_req_q) begin
          issue(sp_al - `CRS_STK_STEP, 1'h1, `CRS_SZ_L, sr_q);
        end else if (mem_ack) begin
          mem_req_q <= 1'h0;
          state_q <= S_PPC;
        end
        S_PPC: if (!mem_req_q) begin
          issue(sp_al - `CRS_STK_STEP, 1'h1, `CRS_SZ_L, epc_q);
        end else if (mem_ack) begin
          mem_req_q <= 1'h0;
          state_q <= S_VEC;
        end
        S_VEC: if (!mem_req_q) begin
          issue(vbr_q + {22'h0, vec_q, 2'h0}, 1'h0, `CRS_SZ_L, 32'h0);
        end else if (mem_ack) begin
          mem_req_q <= 1'h0;
          pc_q <= mem_rdata;
          state_q <= S_RUN;
        end
        S_OPC: if (!mem_req_q) begin
          issue(sp_al, 1'h0, `CRS_SZ_L, 32'h0);
        end else if (mem_ack) begin
          mem_req_q <= 1'h0;
          pc_q <= mem_rdata;
          state_q <= S_OSR;
        end
        S_OSR: if (!mem_req_q) begin
          issue(sp_al, 1'h0, `CRS_SZ_L, 32'h0);
        end else if (mem_ack) begin
          mem_req_q <= 1'h0;
          sr_q <= mem_rdata & `CRS_SR_WMASK;
          state_q <= S_RUN;
        end
        default: state_q <= S_VPC;
      endcase
      // Bus writes land last so software wins over the core
      if (bus_wr_q) begin
        case (bus_idx_q)
          `CRS_IX_SR:   sr_q <= hwdata & `CRS_SR_WMASK;
          `CRS_IX_GBR:  gbr_q <= hwdata;
          `CRS_IX_VBR:  vbr_q <= hwdata;
          `CRS_IX_ACCUMULATOR_HIGH: accumulator_high_q <= hwdata;
          `CRS_IX_ACCUMULATOR_LOW: accumulator_low_q <= hwdata;
          `CRS_IX_PR:   pr_q <= hwdata;
          `CRS_IX_PC:   pc_q <= hwdata;
          `CRS_IX_CTRL: halt_q <= hwdata[`CRS_CTRL_HALT];
          default:      halt_q <= halt_q;
        endcase
      end
    end
  end

  // Stalling on ce keeps the master waiting rather than losing a beat
  assign hreadyout  = ce;
  assign hrdata     = hrdata_q;
  assign hresp      = 1'h0;
  assign fetch_addr = pc_q;
  assign mem_req    = mem_req_q;
  assign mem_addr   = mem_addr_q;
  assign mem_we     = mem_we_q;
  assign mem_size   = mem_size_q;
  assign mem_wdata  = mem_wdata_q;
  assign addr_err   = addr_err_q;
endmodule // crs_core
`default_nettype wire

// >>> rtl/crs_map.vh
/*
  Constants for the core register set: instruction opcodes, operand sizes,
  status word layout, vector offsets and the register index map.
  Assumes it is included once per compile unit by crs_core.v.
*/
`ifndef CRS_MAP_VH
`define CRS_MAP_VH

`define CRS_OP_MOVI    4'h0
`define CRS_OP_ADDI    4'h1
`define CRS_OP_CMPI    4'h2
`define CRS_OP_LOGI    4'h3
`define CRS_OP_LDPC    4'h4
`define CRS_OP_LOAD    4'h5
`define CRS_OP_STORE   4'h6
`define CRS_OP_GBRM    4'h7
`define CRS_OP_ADD     4'h8
`define CRS_OP_MUL     4'h9
`define CRS_OP_MAC     4'ha
`define CRS_OP_BRA     4'hb
`define CRS_OP_BSR     4'hc
`define CRS_OP_BCC     4'hd
`define CRS_OP_CTL     4'he
`define CRS_OP_BITM    4'hf

`define CRS_CTL_RTS    4'h0
`define CRS_CTL_RTE    4'h1
`define CRS_CTL_TRAP   4'h2
`define CRS_CTL_LDC    4'h3
`define CRS_CTL_STC    4'h4
`define CRS_CTL_STS    4'h5
`define CRS_CTL_LDS    4'h6

`define CRS_LG_AND     2'h0
`define CRS_LG_OR      2'h1
`define CRS_LG_XOR     2'h2
`define CRS_LG_TST     2'h3

`define CRS_CS_SR      2'h0
`define CRS_CS_GBR     2'h1
`define CRS_SS_ACCUMULATOR_HIGH    2'h0
`define CRS_SS_ACCUMULATOR_LOW    2'h1

`define CRS_SZ_B       2'h0
`define CRS_SZ_W       2'h1
`define CRS_SZ_L       2'h2

`define CRS_SR_T       0
`define CRS_SR_RESET   32'h000000f0
`define CRS_SR_WMASK   32'h000003f3
`define CRS_VBR_RESET  32'h00000000

`define CRS_VEC_PC_OFF 32'h00000000
`define CRS_VEC_SP_OFF 32'h00000004
`define CRS_VEC_ADRERR 8'h09
`define CRS_STK_STEP   32'h00000004
`define CRS_INSN_STEP  32'h00000002
`define CRS_PC_AHEAD   32'h00000004

`define CRS_HSIZE_WORD 3'h2
`define CRS_IX_SR      5'h10
`define CRS_IX_GBR     5'h11
`define CRS_IX_VBR     5'h12
`define CRS_IX_ACCUMULATOR_HIGH    5'h13
`define CRS_IX_ACCUMULATOR_LOW    5'h14
`define CRS_IX_PR      5'h15
`define CRS_IX_PC      5'h16
`define CRS_IX_STAT    5'h17
`define CRS_IX_CTRL    5'h18
`define CRS_IX_NONE    5'h1f
`define CRS_CTRL_HALT  0
`define CRS_STAT_ERR   0

`endif

// >>> verification/crs_core_chk.sv
/* Checker for crs_core: unmapped bus reads, memory port alignment and holding,
   reset vector fetch, error sequence and fetch stepping.
   Assumes ce is held high by the bench and only its ports are seen. */
`default_nettype none
module crs_core_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        insn_valid,
  input wire logic [15:0] insn,
  input wire logic        insn_ready,
  input wire logic [31:0] fetch_addr,
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_we,
  input wire logic [1:0]  mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic        mem_ack,
  input wire logic        addr_err
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Previous accepted word was an unconditional delayed branch
  logic br_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) br_q <= 1'b0;
    else br_q <= insn_valid && insn_ready && (insn[15:12] == 4'hb || insn[15:12] == 4'hc);
  end

  vec_fetch_a: assert property (
    $rose(hresetn) |-> ##[0:2] (mem_req && mem_addr == 32'h0 && !mem_we))
    else $error("reset did not start with the vector read");
  word_align_a: assert property (mem_req && mem_size == 2'h1 |-> !mem_addr[0])
    else $error("misaligned word request issued");
  long_align_a: assert property (
    mem_req && mem_size == 2'h2 |-> mem_addr[1:0] == 2'h0)
    else $error("misaligned long request issued");
  err_pulse_a: assert property (addr_err |=> !addr_err)
    else $error("address error longer than one cycle");
  err_push_a: assert property (
    addr_err |-> ##[0:4] (mem_req && mem_we && mem_size == 2'h2))
    else $error("no stack push after address error");
  busy_ready_a: assert property (mem_req |-> !insn_ready)
    else $error("instruction accepted during memory access");
  req_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_size))
    else $error("memory request changed before acknowledge");
  bad_read_a: assert property (
    hsel && htrans[1] && hready && !hwrite && hsize == 3'h2 && haddr[31:7] != 25'h0
    |=> hrdata == 32'h0 && !hresp)
    else $error("unmapped read returned data");
  insn_step_a: assert property (
    insn_valid && insn_ready && insn[15:14] == 2'h0 && !br_q
    |=> fetch_addr == $past(fetch_addr) + 32'h2)
    else $error("fetch address did not step by two");
  slot_first_a: assert property (
    br_q && insn_valid && insn_ready |=> fetch_addr == $past(fetch_addr, 2) + 32'h4
    + {{23{$past(insn[7], 2)}}, $past(insn[7:0], 2), 1'b0})
    else $error("branch target wrong after slot");
endmodule // crs_core_chk

bind crs_core crs_core_chk crs_core_chk_i (
  .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hreadyout, .hrdata, .hresp, .insn_valid, .insn, .insn_ready, .fetch_addr, .mem_req,
  .mem_addr, .mem_we, .mem_size, .mem_wdata, .mem_rdata, .mem_ack, .addr_err
);
`default_nettype wire

// >>> verification/cpu_register_set_data_format_test.sv
/* Bench for crs_core: drives the register bus and instruction port and
   answers each memory request one cycle after it rises.
   Assumes a single bus master and ce held high throughout. */
`default_nettype none
module cpu_register_set_data_format_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, ce, hsel, hwrite, insn_valid, mem_ack;
  logic        hreadyout, hresp, insn_ready, mem_req, mem_we, addr_err;
  logic [31:0] haddr, hwdata, hrdata, fetch_addr, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] insn;
  logic [2:0]  hsize;
  logic [1:0]  htrans, mem_size;
  logic [31:0] wq[$];
  int          miscompares = 0;
  int          cmp_count = 0;
  int          err_seen = 0;
  logic [31:0] last_rd, last_wd;

  crs_core crs_core_i (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .insn_valid, .insn, .insn_ready,
    .fetch_addr, .mem_req, .mem_addr, .mem_we, .mem_size, .mem_wdata, .mem_rdata,
    .mem_ack, .addr_err
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Vector table: PC 0x100, SP 0x800, address error handler 0x200
  always @(posedge hclk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= mem_addr == 32'h0 ? 32'h100 : mem_addr == 32'h4 ? 32'h800 :
                 mem_addr == 32'h24 ? 32'h200 : 32'h12348085;
    if (mem_req && mem_ack && mem_we) wq.push_back(mem_addr);
    if (mem_req && mem_ack && mem_we) last_wd <= mem_wdata;
    if (mem_req && mem_ack && !mem_we) last_rd <= mem_addr;
    if (addr_err) err_seen <= err_seen + 1;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Sampled at the rising edge, where the core itself sees the level
  task automatic wait_on(input bit bus);
    for (int n = 0; n < 300; n++) begin
      @(posedge hclk);
      if ((bus ? hreadyout : insn_ready) === 1'b1) return;
    end
    miscompares++;
    give_verdict;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_on(1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask

  task automatic rd_chk(input logic [31:0] a, e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check(v, e);
  endtask

  // Valid stays up so consecutive calls give back-to-back words
  task automatic exec(input logic [15:0] w);
    insn_valid <= 1'b1;
    insn <= w;
    wait_on(1'b0);
  endtask

  task automatic settle;
    insn_valid <= 1'b0;
    wait_on(1'b0);
  endtask

  task automatic t_reset;
    wait_on(1'b0);
    rd_chk(32'h58, 32'h100);
    rd_chk(32'h3c, 32'h800);
    rd_chk(32'h40, 32'hf0);
    rd_chk(32'h48, 32'h0);
    wr(32'h40, 32'hffffffff);
    rd_chk(32'h40, 32'h3f3);
    wr(32'h44, 32'ha5c3_5a3c);
    rd_chk(32'h44, 32'ha5c3_5a3c);
    rd_chk(32'h100, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_imm;
    logic [15:0] prog[8] = '{16'h0180, 16'h1101, 16'h00ff, 16'h300f,
                             16'h3180, 16'h32ff, 16'h3310, 16'h2181};
    time         t0;
    wr(32'h40, 32'h0);
    t0 = $time;
    foreach (prog[i]) exec(prog[i]);
    check(32'(($time - t0) / 10), 32'h8);
    settle;
    rd_chk(32'h4, 32'hffffff81);
    rd_chk(32'h0, 32'h70);
    rd_chk(32'h40, 32'h1);
    $display("immediate test done");
  endtask

  task automatic t_load;
    logic [31:0] ra[3] = '{32'h41, 32'h40, 32'h40};
    logic [15:0] op[3] = '{16'h5210, 16'h5211, 16'h5212};
    logic [31:0] ex[3] = '{32'hffffff85, 32'hffff8085, 32'h12348085};
    wr(32'h4, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(32'h0, ra[i]);
      exec(op[i]);
      settle;
      rd_chk(32'h8, ex[i]);
    end
    check(err_seen, 32'h0);
    $display("load test done");
  endtask

  task automatic t_align;
    logic [31:0] sp;
    for (int i = 0; i < 2; i++) begin
      ahb(1'b0, 32'h3c, 32'h0, sp);
      wr(32'h0, 32'h41 + i);
      wq.delete();
      exec(16'h5211 + i[15:0]);
      settle;
      check(err_seen, i + 1);
      check(wq.size(), 32'h2);
      check(wq[0], sp - 32'h4);
      check(wq[1], sp - 32'h8);
      rd_chk(32'h3c, sp - 32'h8);
      rd_chk(32'h58, 32'h200);
    end
    $display("alignment test done");
  endtask

  task automatic t_mem;
    logic [31:0] p;
    rd_chk(32'h5c, 32'h9);
    wr(32'h5c, 32'h1);
    rd_chk(32'h5c, 32'h8);
    wr(32'h44, 32'h300);
    ahb(1'b0, 32'h58, 32'h0, p);
    exec(16'h4381);
    settle;
    check(last_rd, {p[31:2], 2'h0} + 32'h8);
    rd_chk(32'hc, 32'h12348085);
    exec(16'h7002);
    settle;
    check(last_rd, 32'h308);
    rd_chk(32'h0, 32'h12348085);
    wq.delete();
    exec(16'h7103);
    settle;
    check(wq[0], 32'h30c);
    check(last_wd, 32'h12348085);
    exec(16'hf155);
    settle;
    check(last_rd, 32'h12348385);
    check(wq[1], 32'h12348385);
    check(last_wd, 32'h123480d5);
    wr(32'h60, 32'h1);
    rd_chk(32'h60, 32'h1);
    check(insn_ready, 32'h0);
    wr(32'h60, 32'h0);
    $display("memory test done");
  endtask

  task automatic t_branch;
    logic [31:0] p;
    ahb(1'b0, 32'h58, 32'h0, p);
    exec(16'hc008);
    exec(16'h0507);
    settle;
    check(fetch_addr, p + 32'h14);
    rd_chk(32'h14, 32'h7);
    rd_chk(32'h54, p + 32'h4);
    wr(32'h40, 32'h1);
    ahb(1'b0, 32'h58, 32'h0, p);
    exec(16'hd004);
    settle;
    check(fetch_addr, p + 32'hc);
    $display("branch test done");
  endtask

  task automatic t_mac;
    wr(32'h4, 32'hfffffffd);
    wr(32'h8, 32'h5);
    wr(32'h4c, 32'h0);
    exec(16'h9120);
    settle;
    rd_chk(32'h50, 32'hfffffff1);
    exec(16'ha120);
    settle;
    rd_chk(32'h4c, 32'h0);
    rd_chk(32'h50, 32'hffffffe2);
    $display("multiply test done");
  endtask

  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    insn_valid = 1'b0;
    insn = 16'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_imm;
    t_load;
    t_align;
    t_mem;
    t_branch;
    t_mac;
    give_verdict;
  end
endmodule // cpu_register_set_data_format_test
`default_nettype wire
